// File: hw/pulse_count_led_dimmer.sv
// pulse-count dimming core with shutdown, duty gating and protection
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - start at count zero, full scale
// - current scales as (32 minus count)/32
// - each valid rising edge lowers one step
// - pulse after 31 wraps to full scale
// - narrow low glitches do not count
// - overlong low time ends in shutdown
// - low over 30 ms forces zero-current shutdown
// - dimming input enables and sets level
// - level follows count since enable
// - duty input used purely as logic level
// - pump overvoltage resets logic and pump mode
// - open/short detection always on, disables channel
// - duty high gives level, low gives zero
// - first rising edge from shutdown sets full scale
module pulse_count_led_dimmer
  import dimmer_pkg::*;
#(
  parameter int unsigned SHDN_CYCLES = SHDN_CYC  // shutdown timeout count
) (
  input  wire logic              core_clk,       // 50 MHz core clock
  input  wire logic              srst,           // sync reset, high
  input  wire logic              dim_pulse_input,// one-wire dim pin
  input  wire logic              duty_in,        // duty-cycle gate pin
  input  wire logic              pump_ovp,       // pump_output above 6 V
  input  wire led_det_t          led_det,        // open/short flags
  output logic [CH_NUM-1:0]      ch_enable,      // per-channel drive on
  output logic [4:0]             dim_level,      // 31 - count code
  output logic [4:0]             pulse_count,    // pulses since enable
  output logic                   device_active,  // out of shutdown
  output logic                   pump_restart    // pump mode re-eval
);

  dim_core_t s_reg;   // registered state
  dim_core_t s_next;  // next state

  // level code: 31 is full scale, 0 is 1/32
  function automatic logic [4:0] level_of(input logic [4:0] cnt);
    level_of = 5'h1F - cnt;
  endfunction : level_of

  logic dim_s;    // synchronised dimming level
  logic duty_s;   // synchronised duty level
  logic ovp_s;    // synchronised overvoltage flag
  logic low_min;  // low interval long enough to count
  logic low_max;  // low interval past shutdown limit
  logic [CH_NUM-1:0] ch_ok; // channel not open or shorted

  assign dim_s  = s_reg.dim_sync[1];
  assign duty_s = s_reg.duty_sync[1];
  assign ovp_s  = s_reg.ovp_sync[1];
  // timer holds cycles already spent low, so the rise
  // edge compares against the count minus one
  // interval thresholds from timer
  assign low_min = s_reg.low_tmr >= TMR_W'(MIN_LOW_CYC - 1);
  assign low_max = s_reg.low_tmr >= TMR_W'(SHDN_CYCLES - 1);
  // per-channel fault gate, one copy each
  for (genvar g = 0; g < CH_NUM; g++) begin : g_ch_ok
    // either fault flag keeps this channel dark
    assign ch_ok[g] = ~(s_reg.open_sync1[g] | s_reg.short_sync1[g]);
  end

  // next-state logic
  always_comb begin
    s_next = s_reg;
    // two-flop synchronisers for every pin input
    // costs two cycles of latency on every pin edge
    s_next.dim_sync    = {s_reg.dim_sync[0], dim_pulse_input};
    s_next.duty_sync   = {s_reg.duty_sync[0], duty_in};
    s_next.ovp_sync    = {s_reg.ovp_sync[0], pump_ovp};
    s_next.open_sync0  = led_det.open_det;
    s_next.open_sync1  = s_reg.open_sync0;
    s_next.short_sync0 = led_det.short_det;
    s_next.short_sync1 = s_reg.short_sync0;
    // restart flag is a one-cycle pulse by default
    s_next.pump_restart = 1'b0;
    unique case (s_reg.st)
      ST_OFF: begin
        s_next.low_tmr = '0;
        if (dim_s) begin
          s_next.st    = ST_HIGH;
          s_next.count = COUNT_RESET;
        end
      end
      ST_HIGH: begin
        // cleared so every low interval starts from zero
        s_next.low_tmr = '0;
        if (!dim_s) begin
          s_next.st = ST_LOW;
        end
      end
      ST_LOW: begin
        if (!low_max) begin
          s_next.low_tmr = s_reg.low_tmr + TMR_W'(1);
        end
        if (low_max) begin
          s_next.st    = ST_OFF;
          s_next.count = COUNT_RESET;
        end else if (dim_s) begin
          s_next.st = ST_HIGH;
          if (low_min) begin
            // one step down per rising edge
            // five-bit count wraps 31 to 0
            s_next.count = s_reg.count + 5'h01;
          end
        end
      end
    endcase
    // pin level picks the restart state, so a high pin
    // resumes at full scale without waiting for an edge
    // overvoltage resets control and pump mode
    if (ovp_s) begin
      s_next.st           = dim_s ? ST_HIGH : ST_OFF;
      s_next.count        = COUNT_RESET;
      s_next.low_tmr      = '0;
      s_next.pump_restart = 1'b1;
    end
    s_next.active = (s_next.st != ST_OFF);
    s_next.level  = level_of(s_next.count);
    // duty only as a logic level
    s_next.ch_on  = (s_next.active && duty_s) ? ch_ok : '0;
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_reg         <= '0;
      s_reg.st      <= ST_OFF;
      s_reg.count   <= COUNT_RESET;
      // level code uses the same mapping as at run time
      s_reg.level   <= level_of(COUNT_RESET);
    end else begin
      s_reg <= s_next;
    end
  end

  assign ch_enable     = s_reg.ch_on;
  assign dim_level     = s_reg.level;
  assign pulse_count   = s_reg.count;
  assign device_active = s_reg.active;
  assign pump_restart  = s_reg.pump_restart;

  // checks, all on the core clock and quiet during reset
  // the counted-rise, short-rise, timeout and wrap triggers are spelled as named sequences first

  // rise seen after a low long enough to count
  sequence s_valid_rise;
    s_reg.st == ST_LOW && dim_s && low_min && !low_max && !ovp_s;
  endsequence

  // rise seen after a low too short to count
  sequence s_short_rise;
    s_reg.st == ST_LOW && dim_s && !low_min && !ovp_s;
  endsequence

  // low interval reaching the shutdown limit
  sequence s_overlong_low;
    s_reg.st == ST_LOW && low_max && !ovp_s;
  endsequence

  // counted rise while already at the lowest level
  sequence s_top_rise;
    pulse_count == 5'h1F ##0 s_valid_rise;
  endsequence

  property p_step;
    @(posedge core_clk) disable iff (srst)
      s_valid_rise |=> (pulse_count == $past(pulse_count) + 5'h01);
  endproperty
  a_step: assert property (p_step) else $error("count not stepped");

  // short low leaves the count alone
  property p_glitch;
    @(posedge core_clk) disable iff (srst)
      s_short_rise |=> $stable(pulse_count);
  endproperty
  a_glitch: assert property (p_glitch) else $error("glitch counted");

  // counted rise at the top returns to full scale
  property p_wrap;
    @(posedge core_clk) disable iff (srst)
      s_top_rise |=> (pulse_count == COUNT_RESET && dim_level == 5'h1F);
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap to full");

  // timeout darkens every channel on the next edge
  property p_shdn;
    @(posedge core_clk) disable iff (srst)
      s_overlong_low |=> (!device_active && ch_enable == '0);
  endproperty
  a_shdn: assert property (p_shdn) else $error("no shutdown");

  // level code always mirrors the count
  property p_level;
    @(posedge core_clk) disable iff (srst)
      dim_level == 5'h1F - pulse_count;
  endproperty
  a_level: assert property (p_level) else $error("level mismatch");

  property p_duty;
    @(posedge core_clk) disable iff (srst)
      !duty_s |=> (ch_enable == '0);
  endproperty
  a_duty: assert property (p_duty) else $error("duty low not off");

  // duty high drives every healthy channel
  property p_duty_on;
    @(posedge core_clk) disable iff (srst)
      (duty_s && s_reg.st == ST_HIGH && !ovp_s)
      |=> (ch_enable == $past(ch_ok));
  endproperty
  a_duty_on: assert property (p_duty_on)
    else $error("duty high not driven");

  // overvoltage clears the count and restarts the pump
  property p_ovp;
    @(posedge core_clk) disable iff (srst)
      ovp_s |=> (pump_restart && pulse_count == COUNT_RESET);
  endproperty
  a_ovp: assert property (p_ovp) else $error("ovp not handled");

  // restart pulse only follows an overvoltage cycle
  property p_restart_src;
    @(posedge core_clk) disable iff (srst)
      pump_restart |-> $past(ovp_s);
  endproperty
  a_restart_src: assert property (p_restart_src)
    else $error("restart without overvoltage");

  property p_det;
    @(posedge core_clk) disable iff (srst)
      1'b1 |=> ((ch_enable & $past(s_reg.open_sync1 | s_reg.short_sync1))
      == '0);
  endproperty
  a_det: assert property (p_det) else $error("faulty ch on");

  // wake from shutdown at full scale
  property p_wake;
    @(posedge core_clk) disable iff (srst)
      (s_reg.st == ST_OFF && dim_s && !ovp_s) |=> (pulse_count ==
        COUNT_RESET && device_active);
  endproperty
  a_wake: assert property (p_wake) else $error("wake not full");

  // the count never moves in the high state unless overvoltage clears it
  property p_high_hold;
    @(posedge core_clk) disable iff (srst)
      (s_reg.st == ST_HIGH && !ovp_s) |=> $stable(pulse_count);
  endproperty
  a_high_hold: assert property (p_high_hold)
    else $error("count moved while high");

  // low timer advances one per cycle until its limit
  property p_tmr_step;
    @(posedge core_clk) disable iff (srst)
      (s_reg.st == ST_LOW && !low_max && !ovp_s)
      |=> (s_reg.low_tmr == $past(s_reg.low_tmr) + TMR_W'(1));
  endproperty
  a_tmr_step: assert property (p_tmr_step)
    else $error("low timer not stepped");

  // awake flag tracks the control state
  property p_active;
    @(posedge core_clk) disable iff (srst)
      device_active == (s_reg.st != ST_OFF);
  endproperty
  a_active: assert property (p_active)
    else $error("awake flag out of step");

  // a sleeping device drives no channel
  property p_off_dark;
    @(posedge core_clk) disable iff (srst)
      !device_active |-> (ch_enable == '0);
  endproperty
  a_off_dark: assert property (p_off_dark)
    else $error("channel on in shutdown");

  // shutdown holds the count at zero
  property p_off_count;
    @(posedge core_clk) disable iff (srst)
      (s_reg.st == ST_OFF) |-> (pulse_count == COUNT_RESET);
  endproperty
  a_off_count: assert property (p_off_count)
    else $error("count kept in shutdown");

endmodule : pulse_count_led_dimmer
`default_nettype wire

// File: hw/dimmer_pkg.sv
// shared constants and carrier types for the pulse-count led dimmer
package dimmer_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 20;
  // least pulse low time in ns, rounded up to cycles
  localparam int unsigned MIN_LOW_NS      = 200;
  localparam int unsigned MIN_LOW_CYC     =
    (MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest pulse low time in us, rounded down to cycles
  localparam int unsigned MAX_LOW_US      = 100;
  localparam int unsigned MAX_LOW_CYC     = MAX_LOW_US * 1000 / CLK_PERIOD_NS;
  // shutdown timeout in ms, rounded down to cycles
  localparam int unsigned SHDN_MS         = 30;
  localparam int unsigned SHDN_CYC        = SHDN_MS * 50_000;
  localparam int unsigned LEVELS          = 32;
  localparam int unsigned CH_NUM          = 6;
  localparam int unsigned FULL_SCALE_UA   = 25000;
  localparam logic [4:0]  COUNT_RESET     = 5'h00;
  localparam int unsigned TMR_W           = 21;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_HIGH,
    ST_LOW
  } dim_state_t;

  // whole state of the dimmer core
  typedef struct packed {
    dim_state_t           st;
    logic [4:0]           count;
    logic [TMR_W-1:0]     low_tmr;
    logic [1:0]           dim_sync;
    logic [1:0]           duty_sync;
    logic [1:0]           ovp_sync;
    logic [CH_NUM-1:0]    open_sync0;
    logic [CH_NUM-1:0]    open_sync1;
    logic [CH_NUM-1:0]    short_sync0;
    logic [CH_NUM-1:0]    short_sync1;
    logic [CH_NUM-1:0]    ch_on;
    logic [4:0]           level;
    logic                 active;
    logic                 pump_restart;
  } dim_core_t;

  // per-channel detection inputs
  typedef struct packed {
    logic [CH_NUM-1:0] open_det;
    logic [CH_NUM-1:0] short_det;
  } led_det_t;
endpackage : dimmer_pkg

// File: verification/host_model.sv
// host model driving the dimming and duty pins
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic core_clk,        // core clock
  output logic      dim_pulse_input, // one-wire dim pin
  output logic      duty_in          // duty gate pin
);
  // pins idle: dim low (off), duty high
  initial begin
    dim_pulse_input = 1'b0;
    duty_in         = 1'b1;
  end
  // put a level on the dim pin and hold it n cycles
  task automatic drive_dim(input logic v, input int n);
    dim_pulse_input = v;
    repeat (n) @(negedge core_clk);
  endtask : drive_dim
  // hold dim low for n cycles, changed on falling edges
  task automatic dim_low(input int n);
    drive_dim(1'b0, n);
  endtask : dim_low
  // low then high, high held 240 ns
  task automatic dim_pulse(input int low_cyc);
    drive_dim(1'b0, low_cyc);
    drive_dim(1'b1, 12);
  endtask : dim_pulse
  // duty level, then let the sync flops settle
  task automatic set_duty(input logic v);
    duty_in = v;
    repeat (6) @(negedge core_clk);
  endtask : set_duty
endmodule : host_model
`default_nettype wire

// File: verification/tb.sv
// self-checking bench for the pulse-count dimmer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dimmer_pkg::*;
  localparam int unsigned SHDN = 200;   // short timeout keeps run brief
  logic              core_clk;          // 50 MHz
  logic              srst;              // sync reset
  logic              pump_ovp;          // overvoltage flag
  led_det_t          led_det;           // open/short flags
  wire logic         dim_pulse_input;   // from host
  wire logic         duty_in;           // from host
  logic [CH_NUM-1:0] ch_enable;         // channel drive
  logic [4:0]        dim_level;         // level code
  logic [4:0]        pulse_count;       // counted pulses
  logic              device_active;     // awake flag
  logic              pump_restart;      // pump re-eval pulse
  logic              saw;               // restart pulse seen
  int                fails;             // mismatches
  int                num_checks;        // comparisons
  host_model i_host (.core_clk(core_clk), .dim_pulse_input(dim_pulse_input),
    .duty_in(duty_in));
  pulse_count_led_dimmer #(.SHDN_CYCLES(SHDN)) i_dut (.core_clk(core_clk),
    .srst(srst), .dim_pulse_input(dim_pulse_input), .duty_in(duty_in),
    .pump_ovp(pump_ovp), .led_det(led_det), .ch_enable(ch_enable),
    .dim_level(dim_level), .pulse_count(pulse_count),
    .device_active(device_active), .pump_restart(pump_restart));
  // free-running clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // fault inputs, changed on a falling edge
  task automatic set_faults(input led_det_t det, input logic ovp);
    led_det  = det;
    pump_ovp = ovp;
  endtask : set_faults
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  // awake at full scale with all channels driven
  task automatic full_scale();
    chk({7'h00, device_active}, 8'h01);
    chk({3'h0, pulse_count}, 8'h00);
    chk({3'h0, dim_level}, 8'h1F);
    chk({2'h0, ch_enable}, 8'h3F);
  endtask : full_scale
  // every level, then the wrap back to full scale
  task automatic t_steps();
    for (int n = 1; n <= 32; n++) begin
      i_host.dim_pulse(12);
      chk({3'h0, pulse_count}, 8'(n % 32));
      chk({3'h0, dim_level}, 8'(31 - n % 32));
    end
    full_scale();
  endtask : t_steps
  // short lows are glitches; one cycle under the minimum too
  task automatic t_glitch();
    i_host.dim_pulse(12);
    i_host.dim_pulse(4);
    chk({3'h0, pulse_count}, 8'h01);
    i_host.dim_pulse(MIN_LOW_CYC - 1);
    chk({3'h0, pulse_count}, 8'h01);
    i_host.dim_pulse(MIN_LOW_CYC);
    chk({3'h0, pulse_count}, 8'h02);
  endtask : t_glitch
  // duty gate, then one open and one shorted channel
  task automatic t_gate();
    i_host.set_duty(1'b0);
    chk({2'h0, ch_enable}, 8'h00);
    i_host.set_duty(1'b1);
    set_faults(led_det_t'{open_det: 6'h04, short_det: 6'h10}, 1'b0);
    repeat (6) @(negedge core_clk);
    chk({2'h0, ch_enable}, 8'h2B);
    set_faults('0, 1'b0);
    repeat (6) @(negedge core_clk);
  endtask : t_gate
  // one overvoltage cycle restarts logic and pump
  task automatic t_ovp();
    saw = 1'b0;
    set_faults('0, 1'b1);
    @(negedge core_clk);
    set_faults('0, 1'b0);
    repeat (8) @(negedge core_clk) saw |= pump_restart;
    chk({7'h00, saw}, 8'h01);
    full_scale();
  endtask : t_ovp
  // long low shuts down, next rise wakes at full scale
  task automatic t_shdn();
    i_host.dim_pulse(SHDN - 1);
    chk({3'h0, pulse_count}, 8'h01);
    chk({7'h00, device_active}, 8'h01);
    i_host.dim_low(SHDN + 10);
    chk({7'h00, device_active}, 8'h00);
    chk({2'h0, ch_enable}, 8'h00);
    i_host.dim_pulse(1);
    full_scale();
  endtask : t_shdn
  // reset mid-run clears the count, then the high pin wakes it
  task automatic t_reset();
    i_host.dim_pulse(12);
    chk({3'h0, pulse_count}, 8'h01);
    srst = 1'b1;
    repeat (2) @(negedge core_clk);
    chk({3'h0, pulse_count}, 8'h00);
    chk({3'h0, dim_level}, 8'h1F);
    chk({7'h00, device_active}, 8'h00);
    srst = 1'b0;
    @(negedge core_clk);
    chk({2'h0, ch_enable}, 8'h00);
    repeat (4) @(negedge core_clk);
    full_scale();
  endtask : t_reset
  // main sequence
  initial begin
    fails = 0;
    num_checks = 0;
    srst = 1'b1;
    set_faults('0, 1'b0);
    repeat (20) @(negedge core_clk);
    srst = 1'b0;
    @(negedge core_clk);
    chk({2'h0, ch_enable}, 8'h00);
    i_host.dim_pulse(12);
    full_scale();
    t_steps();
    t_glitch();
    t_gate();
    t_ovp();
    t_shdn();
    t_reset();
    close_out();
  end
  // watchdog, run needs about 1400 cycles
  initial begin
    #200us;
    fails++;
    close_out();
  end
endmodule : tb
`default_nettype wire
